// ---- core/rsp_placer.sv ----
// Operation
// - Slots are chosen for a latency bound no shorter than 4 ms, or else for a minimum block length.
// - A row component uses one block per zone at the highest offset that fits in every zone.
// - Column blocks are placed inside the first eight slots of their zones whenever possible.
// - Failing that, column blocks are chosen to keep the highest slot used as low as possible.
// - Among equal candidates, zones are taken from the earliest preference set 8, 4/12, even, odd.
// - Within the same preference set, the zone whose block ends lowest is taken first.
// - Each column block starts at the earliest available slot of its zone.
// - A change of slot availability forces a re-check, unless a refused request is taken in the cycle it would start, and any fix lands within 32 superframes.
// - Oversize requests may ignore the location preferences and take the first zones that fit.
// - Zone zero never carries a column block.
`default_nettype none
module rsp_placer (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic start_in,
   input wire rsp_pkg::rsp_req_type req_in,
   input wire logic [rsp_pkg::MAP_W-1:0] avail_in,
   input wire logic avail_change_in,
   input wire logic sf_tick_in,
   output logic busy_out,
   output logic [rsp_pkg::MAP_W-1:0] place_out,
   output rsp_pkg::rsp_status_type status_out
);
   import rsp_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ROW = 4'b0010,
      ST_COL = 4'b0100,
      ST_DONE = 4'b1000
   } rsp_state_type;

   // Mask of len ones at the bottom
   function automatic logic [SLOTS-1:0] len_mask(input logic [4:0] len);
      logic [SLOTS:0] m;
      m = (17'h0_0001 << len) - 17'h0_0001;
      return m[SLOTS-1:0];
   endfunction

   function automatic rsp_fit_type fit_first(input logic [SLOTS-1:0] m, input logic [4:0] len);
      rsp_fit_type f;
      logic [SLOTS-1:0] k;
      f = '0;
      k = len_mask(len);
      for (int s = SLOTS - 1; s >= 0; s--) begin
         if ((5'(s) + len <= 5'(SLOTS)) && (((m >> s) & k) == k) && (len != 5'h0_0)) begin
            f.ok = 1'b1;
            f.start = 4'(s);
         end
      end
      return f;
   endfunction

   function automatic rsp_fit_type fit_last(input logic [SLOTS-1:0] m, input logic [4:0] len);
      rsp_fit_type f;
      logic [SLOTS-1:0] k;
      f = '0;
      k = len_mask(len);
      for (int s = 0; s < SLOTS; s++) begin
         if ((5'(s) + len <= 5'(SLOTS)) && (((m >> s) & k) == k) && (len != 5'h0_0)) begin
            f.ok = 1'b1;
            f.start = 4'(s);
         end
      end
      return f;
   endfunction

   function automatic logic [1:0] zone_rank(input logic [3:0] z);
      if (z == ZONE_MID) begin
         return RANK_SET0;
      end else if (z[1:0] == 2'h0 && z != 4'h0) begin
         return RANK_SET1;
      end else if (z[0] == 1'b0 && z != 4'h0) begin
         return RANK_SET2;
      end
      return RANK_SET3;
   endfunction

   rsp_state_type state_reg, state_next;
   rsp_req_type req_reg, req_next;
   logic [MAP_W-1:0] work_reg, work_next;
   logic [MAP_W-1:0] place_reg, place_next;
   logic [ZONES-1:0] used_reg, used_next;
   logic [4:0] picks_reg, picks_next;
   logic [5:0] sf_cnt_reg, sf_cnt_next;
   logic recheck_reg, recheck_next;
   rsp_status_type stat_reg, stat_next;

   // Slots free in every zone taking part in a row component
   logic [SLOTS-1:0] row_common;
   // zone z owns map bits z*SLOTS up
   always_comb begin
      row_common = '1;
      for (int z = 0; z < ZONES; z++) begin
         if (!(z == 0 && req_reg.skip_zone0)) begin
            row_common = row_common & avail_in[z*SLOTS +: SLOTS];
         end
      end
   end

   // Best remaining zone for the next column block
   logic best_ok;
   logic [3:0] best_zone;
   logic [3:0] best_start;
   always_comb begin
      rsp_fit_type f;
      logic [3:0] end_slot;
      logic over;
      logic [10:0] key;
      logic [10:0] best_key;
      f = '0;
      end_slot = '0;
      over = 1'b0;
      key = '0;
      best_key = '1;
      best_ok = 1'b0;
      best_zone = '0;
      best_start = '0;
      for (int z = 1; z < ZONES; z++) begin
         f = fit_first(avail_in[z*SLOTS +: SLOTS], req_reg.len);
         end_slot = f.start + req_reg.len[3:0] - 4'h1;
         over = (f.start + req_reg.len) > {1'b0, COL_EARLY_SLOTS};
         // early fit first, then lowest end slot
         // then preference set, then lowest end
         key = {over, over ? end_slot : 4'h0, zone_rank(4'(z)), end_slot};
         // oversize takes zones in plain order
         if (req_reg.oversize) begin
            key = {7'h00, 4'(z)};
         end
         if (f.ok && !used_reg[z] && (!best_ok || key < best_key)) begin
            best_ok = 1'b1;
            best_key = key;
            best_zone = 4'(z);
            best_start = f.start;
         end
      end
   end

   // Search engine and commit of placements
   always_comb begin
      rsp_fit_type rf;
      logic differs;
      state_next = state_reg;
      req_next = req_reg;
      work_next = work_reg;
      place_next = place_reg;
      used_next = used_reg;
      picks_next = picks_reg;
      sf_cnt_next = sf_cnt_reg;
      recheck_next = recheck_reg | avail_change_in;
      stat_next = stat_reg;
      rf = fit_last(row_common, req_reg.len);
      differs = (work_reg != place_reg);
      // superframes counted while a fix is outstanding; a finished check clears them below
      if (recheck_reg || stat_reg.pending) begin
         if (sf_tick_in && sf_cnt_reg != COMPACTION_DEADLINE_SF) begin
            sf_cnt_next = sf_cnt_reg + 6'h01;
         end
      end
      if (sf_cnt_reg == COMPACTION_DEADLINE_SF) begin
         stat_next.late = 1'b1;
      end
      case (state_reg)
         ST_IDLE: begin
            if (start_in || recheck_reg) begin
               recheck_next = avail_change_in;
               work_next = '0;
               used_next = '0;
               picks_next = '0;
               stat_next.fail = 1'b0;
               // latency mode or the row flag selects the row component
               if (start_in && req_in.latency_mode && req_in.latency_us < MIN_LATENCY_US) begin
                  // Refused request is not kept, so a later re-check reuses the last good one
                  stat_next.fail = 1'b1;
                  stat_next.valid = 1'b0;
               end else begin
                  if (start_in) begin
                     req_next = req_in;
                     req_next.row = req_in.row | req_in.latency_mode;
                  end
                  if (start_in ? (req_in.row || req_in.latency_mode) : req_reg.row) begin
                     state_next = ST_ROW;
                  end else begin
                     state_next = ST_COL;
                  end
               end
            end
         end
         ST_ROW: begin
            // one block per zone at the same offset
            if (rf.ok) begin
               for (int z = 0; z < ZONES; z++) begin
                  if (!(z == 0 && req_reg.skip_zone0)) begin
                     work_next[z*SLOTS +: SLOTS] = len_mask(req_reg.len) << rf.start;
                  end
               end
            end else begin
               stat_next.fail = 1'b1;
            end
            state_next = ST_DONE;
         end
         ST_COL: begin
            if (picks_reg == req_reg.count) begin
               state_next = ST_DONE;
            end else if (!best_ok) begin
               stat_next.fail = 1'b1;
               state_next = ST_DONE;
            end else begin
               work_next[best_zone*SLOTS +: SLOTS] = len_mask(req_reg.len) << best_start;
               used_next[best_zone] = 1'b1;
               picks_next = picks_reg + 5'h0_1;
            end
         end
         ST_DONE: begin
            // a differing result waits for the next superframe
            if (stat_reg.fail) begin
               place_next = '0;
               stat_next.valid = 1'b0;
               stat_next.pending = 1'b0;
               sf_cnt_next = '0;
               state_next = ST_IDLE;
            end else if (!differs) begin
               stat_next.valid = 1'b1;
               stat_next.pending = 1'b0;
               stat_next.late = 1'b0;
               sf_cnt_next = '0;
               state_next = ST_IDLE;
            end else begin
               stat_next.pending = 1'b1;
               if (sf_tick_in) begin
                  place_next = work_reg;
                  stat_next.valid = 1'b1;
                  stat_next.pending = 1'b0;
                  sf_cnt_next = '0;
                  state_next = ST_IDLE;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         state_reg <= ST_IDLE;
         req_reg <= '0;
         work_reg <= '0;
         place_reg <= '0;
         used_reg <= '0;
         picks_reg <= '0;
         sf_cnt_reg <= '0;
         recheck_reg <= 1'b0;
         stat_reg <= '0;
      end else begin
         state_reg <= state_next;
         req_reg <= req_next;
         work_reg <= work_next;
         place_reg <= place_next;
         used_reg <= used_next;
         picks_reg <= picks_next;
         sf_cnt_reg <= sf_cnt_next;
         recheck_reg <= recheck_next;
         stat_reg <= stat_next;
      end
   end

   // Outputs
   assign busy_out = (state_reg != ST_IDLE);
   assign place_out = place_reg;
   assign status_out = stat_reg;
endmodule
`default_nettype wire

// ---- include/rsp_pkg.sv ----
`default_nettype none
package rsp_pkg;
   // Superframe geometry
   localparam int ZONES = 16;
   localparam int SLOTS = 16;
   localparam int MAP_W = ZONES * SLOTS;
   // Column blocks should end inside this many leading slots of a zone
   localparam logic [3:0] COL_EARLY_SLOTS = 4'h8;
   // Superframes allowed to bring placements back into line after a change
   localparam logic [5:0] COMPACTION_DEADLINE_SF = 6'h20;
   // Shortest latency that may drive slot selection, in microseconds
   localparam logic [15:0] MIN_LATENCY_US = 16'h0FA0;
   // Zone preference ranks, earlier set is better
   localparam logic [1:0] RANK_SET0 = 2'h0;
   localparam logic [1:0] RANK_SET1 = 2'h1;
   localparam logic [1:0] RANK_SET2 = 2'h2;
   localparam logic [1:0] RANK_SET3 = 2'h3;
   localparam logic [3:0] ZONE_MID = 4'h8;

   // Placement request from the reservation manager
   typedef struct packed {
      logic latency_mode;        // Slots chosen for latency, else for block length
      logic row;                 // Row component, else column component
      logic skip_zone0;          // Row component leaves zone zero out
      logic oversize;            // Slots come from an oversize reservation_element
      logic [15:0] latency_us;   // Latency bound in latency mode
      logic [4:0] len;           // Block length in medium_slot units, 1 to 16
      logic [4:0] count;         // Column blocks wanted, one per zone
   } rsp_req_type;

   // Result of an earliest-fit or latest-fit search in one slot map
   typedef struct packed {
      logic ok;
      logic [3:0] start;
   } rsp_fit_type;

   // Placement status
   typedef struct packed {
      logic valid;               // Placement in force satisfies the request
      logic fail;                // No legal placement exists
      logic pending;             // New placement waits for a superframe boundary
      logic late;                // Compaction deadline passed
   } rsp_status_type;
endpackage
`default_nettype wire

// ---- bench/rsp_placer_assertions.sv ----
`default_nettype none
module rsp_placer_assertions
   import rsp_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic start_in,
   input wire rsp_req_type req_in,
   input wire logic [MAP_W-1:0] avail_in,
   input wire logic avail_change_in,
   input wire logic sf_tick_in,
   input wire logic busy_out,
   input wire logic [MAP_W-1:0] place_out,
   input wire rsp_status_type status_out
);
   timeunit 1ns;
   timeprecision 1ns;
   rsp_req_type lreq_reg, lreq_next;
   logic [5:0] sf_reg, sf_next;
   logic refused, lrow, same;
   assign refused = req_in.latency_mode && req_in.latency_us < MIN_LATENCY_US;
   assign lrow = lreq_reg.row || lreq_reg.latency_mode;
   // Last accepted request and superframes spent busy
   always_comb begin
      lreq_next = (start_in && !busy_out && !refused) ? req_in : lreq_reg;
      sf_next = busy_out ? sf_reg + {5'h0, sf_tick_in} : 6'h0;
   end
   always_ff @(posedge core_clk_in) begin
      lreq_reg <= srst_in ? '0 : lreq_next;
      sf_reg <= srst_in ? 6'h0 : sf_next;
   end
   // Every zone repeats zone one, zone zero unless skipped
   always_comb begin
      same = 1'b1;
      for (int z = 0; z < ZONES; z++) begin
         if (place_out[z*SLOTS +: SLOTS] != place_out[SLOTS +: SLOTS]
             && (z != 0 || !lreq_reg.skip_zone0)) begin
            same = 1'b0;
         end
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   sequence take_s;
      start_in && !busy_out;
   endsequence
   sequence held_s;
      !busy_out && status_out.valid;
   endsequence
   lat_guard_a: assert property (take_s ##0 refused |=> status_out.fail && !busy_out)
      else $error("short latency not refused");
   search_start_a: assert property (take_s ##0 !refused |=> busy_out)
      else $error("search did not start");
   sf_deadline_a: assert property (busy_out |-> sf_reg <= COMPACTION_DEADLINE_SF)
      else $error("compaction deadline passed");
   commit_tick_a: assert property (
      $changed(place_out) && status_out.valid |-> $past(sf_tick_in))
      else $error("commit off the superframe edge");
   free_slots_a: assert property (
      $changed(place_out) |-> (place_out & ~$past(avail_in)) == '0)
      else $error("placement on a busy slot");
   col_zone0_a: assert property (held_s ##0 !lrow |-> place_out[SLOTS-1:0] == '0)
      else $error("column block in zone zero");
   row_equal_a: assert property (held_s ##0 lrow |-> same)
      else $error("row zones differ");
   col_count_a: assert property (
      held_s ##0 !lrow |-> $countones(place_out) == lreq_reg.count * lreq_reg.len)
      else $error("column slot count wrong");
endmodule
bind rsp_placer rsp_placer_assertions i_chk (.core_clk_in(core_clk_in),
   .srst_in(srst_in), .start_in(start_in), .req_in(req_in), .avail_in(avail_in),
   .avail_change_in(avail_change_in), .sf_tick_in(sf_tick_in), .busy_out(busy_out),
   .place_out(place_out), .status_out(status_out));
`default_nettype wire

// ---- bench/rsp_peer_model.sv ----
`default_nettype none
module rsp_peer_model (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic [2:0] mode_in,
   output logic [255:0] avail_out,
   output logic change_out,
   output logic tick_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] mode_reg;
   logic [5:0] cnt_reg;
   // Slots held by neighbours are cleared from the free map
   always_comb begin
      avail_out = '1;
      for (int i = 0; i < 256; i++) begin
         if ((mode_reg == 3'h1 && i == 128) || (mode_reg == 3'h2 && i[7:3] == 5'h10)
             || (mode_reg == 3'h3 && i[3:0] < ((i[7:4] == 4'h7) ? 8 : 10))
             || (mode_reg == 3'h4 && i > 15)
             || (mode_reg == 3'h5 && (i[7:3] == 5'h10 || i == 64))) begin
            avail_out[i] = 1'b0;
         end
      end
   end
   // New beacon contents flag a change; a superframe lasts 40 cycles
   always_ff @(posedge core_clk_in) begin
      mode_reg <= srst_in ? 3'h0 : mode_in;
      change_out <= !srst_in && mode_in != mode_reg;
      cnt_reg <= (srst_in || cnt_reg == 6'h27) ? 6'h0 : cnt_reg + 6'h1;
      tick_out <= cnt_reg == 6'h27;
   end
endmodule
`default_nettype wire

// ---- bench/reservation_slot_placement_test.sv ----
`default_nettype none
module reservation_slot_placement_test;
   timeunit 1ns;
   timeprecision 1ns;
   import rsp_pkg::*;
   logic clk = 1'b0, srst = 1'b1, start = 1'b0, busy, chg, tick;
   logic [2:0] mode = 3'h0;
   rsp_req_type req = '0;
   logic [MAP_W-1:0] avail, place, want;
   rsp_status_type status;
   int miscompares = 0, comparisons = 0;
   always #50 clk = ~clk;
   rsp_placer i_dut (.core_clk_in(clk), .srst_in(srst), .start_in(start),
      .req_in(req), .avail_in(avail), .avail_change_in(chg), .sf_tick_in(tick),
      .busy_out(busy), .place_out(place), .status_out(status));
   rsp_peer_model i_peer (.core_clk_in(clk), .srst_in(srst), .mode_in(mode),
      .avail_out(avail), .change_out(chg), .tick_out(tick));
   task automatic test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [MAP_W-1:0] exp, seen);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   function automatic logic [MAP_W-1:0] blk(input int z, s, n);
      blk = '0;
      for (int i = 0; i < n; i++) blk[z*SLOTS+s+i] = 1'b1;
   endfunction
   task automatic verdict(input logic [MAP_W-1:0] m, input logic [3:0] st);
      check("place", m, place);
      check("status", st, status);
   endtask
   // Bounded wait for the placer to go idle
   task automatic idle;
      int n;
      n = 0;
      repeat (6) @(posedge clk);
      #1;
      while (busy !== 1'b0 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("busy", '0, busy);
   endtask
   // Flags are latency, row, skip zone zero, oversize
   task automatic run(input logic [3:0] f, input logic [15:0] us, input logic [4:0] l, c);
      @(posedge clk);
      req <= '{f[3], f[2], f[1], f[0], us, l, c};
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      idle();
   endtask
   task automatic setmode(input logic [2:0] m);
      @(posedge clk);
      mode <= m;
      idle();
   endtask
   // Short bound refused; least legal bound gives the highest row
   task automatic t_latency;
      run(4'h8, 16'h0F9F, 5'h04, 5'h00);
      verdict('0, 4'h4);
      run(4'h8, MIN_LATENCY_US, 5'h04, 5'h00);
      want = '0;
      for (int z = 0; z < ZONES; z++) want |= blk(z, 12, 4);
      verdict(want, 4'h8);
      run(4'h6, 16'h0000, 5'h10, 5'h00);
      verdict({{240{1'b1}}, 16'h0000}, 4'h8);
   endtask
   // Preference order, then a change moves the block up one slot
   task automatic t_column;
      run(4'h0, 16'h0000, 5'h03, 5'h07);
      want = '0;
      for (int z = 2; z < ZONES; z += 2) want |= blk(z, 0, 3);
      verdict(want, 4'h8);
      run(4'h0, 16'h0000, 5'h02, 5'h01);
      verdict(blk(8, 0, 2), 4'h8);
      setmode(3'h1);
      verdict(blk(8, 1, 2), 4'h8);
   endtask
   // Early slots beat zone rank; then the highest slot is kept low
   task automatic t_late;
      setmode(3'h2);
      run(4'h0, 16'h0000, 5'h02, 5'h02);
      verdict(blk(4, 0, 2) | blk(12, 0, 2), 4'h8);
      // Equal rank, zone twelve ends lower than zone four
      setmode(3'h5);
      run(4'h0, 16'h0000, 5'h02, 5'h01);
      verdict(blk(12, 0, 2), 4'h8);
      setmode(3'h3);
      run(4'h0, 16'h0000, 5'h02, 5'h01);
      verdict(blk(7, 8, 2), 4'h8);
   endtask
   // Oversize takes the lowest zones past zero; no room fails
   task automatic t_oversize;
      setmode(3'h0);
      run(4'h1, 16'h0000, 5'h03, 5'h02);
      verdict(blk(1, 0, 3) | blk(2, 0, 3), 4'h8);
      setmode(3'h4);
      run(4'h0, 16'h0000, 5'h02, 5'h01);
      verdict('0, 4'h4);
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      #1;
      verdict('0, 4'h0);
      t_latency();
      t_column();
      t_late();
      t_oversize();
      test_done();
   end
   // Watchdog far beyond the several hundred cycles needed
   initial begin
      #2000000;
      miscompares++;
      test_done();
   end
endmodule
`default_nettype wire
